// file: return_and_rotate_exec.sv
/*
 * Execution of subroutine return, interrupt return, return with literal and
 * rotate left through carry, with the program counter, accumulator, carry
 * and global interrupt enable held here.
 * Assumes one instruction cycle per clk, instr valid with instr_valid, and
 * file_rdata holding the register addressed by instr[6:0] in the same cycle.
 */
`timescale 1ns/10ps
`default_nettype none

// Contract
// [RQ1] Interrupt return pops the stack and loads top of stack into PC.
// [RQ2] Interrupt return sets global interrupt enable, control bit 7; flags untouched.
// [RQ3] Interrupt return decoded from its fixed 14-bit code; one word, two cycles.
// [RQ4] Return with literal loads the accumulator with the low byte; bits 9:8 ignored.
// [RQ5] Return with literal pops stack into PC, flags unchanged.
// [RQ6] Return with literal is one word, two cycles.
// [RQ7] Plain return pops stack into PC without touching flags.
// [RQ8] Plain return takes two cycles.
// [RQ9] Destination bit 0 writes the accumulator, 1 writes the file register.
// [RQ10] Rotate left: shift left, old carry into bit 0, bit 7 into carry, one cycle.
// [RQ11] Stack pops flush the prefetched word; the second cycle is a no-operation.
module return_and_rotate_exec
    import return_and_rotate_pkg::*;
#(
    parameter int PC_W = DEF_PC_W,
    parameter logic [13:0] RETURN_CODE = 14'h0008
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic instr_valid,
    input wire logic [INSTR_W-1:0] instr,
    input wire logic [PC_W-1:0] top_of_stack,
    input wire logic [DATA_W-1:0] file_rdata,
    output logic [PC_W-1:0] pc,
    output logic [DATA_W-1:0] accumulator,
    output logic carry,
    output logic global_interrupt_enable,
    output logic [DATA_W-1:0] interrupt_control_set,
    output logic stack_pop,
    output logic flush,
    output logic file_we,
    output logic [FADDR_W-1:0] file_addr,
    output logic [DATA_W-1:0] file_wdata
);

    if (PC_W < 1 || PC_W > 16) begin : g_pc_check
        $error("PC_W must lie between 1 and 16");
    end

    // The plain return code must not alias another decoded instruction
    if (RETURN_CODE == RETURN_FROM_INTERRUPT_CODE ||
        RETURN_CODE[RETLIT_OP_HI:RETLIT_OP_LO] == RETLIT_OP ||
        RETURN_CODE[ROT_OP_HI:ROT_OP_LO] == ROT_OP) begin : g_code_check
        $error("RETURN_CODE collides with another decoded instruction");
    end

    ////////////////////////////////////////////////////////////////////////
    // Decode

    function automatic logic is_pop(input logic [INSTR_W-1:0] w, input logic [13:0] ret_code);
        is_pop = (w == RETURN_FROM_INTERRUPT_CODE) || (w == ret_code) ||
                 (w[RETLIT_OP_HI:RETLIT_OP_LO] == RETLIT_OP);
    endfunction : is_pop

    exec_state_t state;
    exec_state_t next_state;
    logic [PC_W-1:0] next_pc;
    logic [DATA_W-1:0] next_accumulator;
    logic next_carry;
    logic next_enable;
    logic [DATA_W-1:0] next_icr_set;
    logic next_stack_pop;
    logic next_flush;
    logic next_file_we;
    logic [FADDR_W-1:0] next_file_addr;
    logic [DATA_W-1:0] next_file_wdata;

    logic go;
    logic dec_reti;
    logic dec_retlit;
    logic dec_rot;
    logic [DATA_W-1:0] rot_result;

    assign go = (state == ST_EXEC) && instr_valid;
    assign dec_reti = (instr == RETURN_FROM_INTERRUPT_CODE);                 // [RQ3]
    assign dec_retlit = (instr[RETLIT_OP_HI:RETLIT_OP_LO] == RETLIT_OP);     // [RQ4]
    assign dec_rot = (instr[ROT_OP_HI:ROT_OP_LO] == ROT_OP);
    assign rot_result = {file_rdata[MSB_BIT-1:0], carry};                   // [RQ10]

    ////////////////////////////////////////////////////////////////////////
    // Next values

    always_comb begin
        next_state = state;
        next_pc = pc;
        next_accumulator = accumulator;
        next_carry = carry;
        next_enable = global_interrupt_enable;
        next_icr_set = BYTE_ZERO;
        next_stack_pop = 1'b0;
        next_flush = 1'b0;
        next_file_we = 1'b0;
        next_file_addr = file_addr;
        next_file_wdata = file_wdata;
        case (state)
            ST_EXEC: begin
                if (instr_valid) begin
                    if (is_pop(instr, RETURN_CODE)) begin
                        next_pc = top_of_stack;                               // [RQ1] [RQ5] [RQ7]
                        next_stack_pop = 1'b1;
                        next_flush = 1'b1;                                    // [RQ11]
                        next_state = ST_FLUSH;                                // [RQ3] [RQ6] [RQ8]
                        if (dec_reti) begin
                            next_enable = 1'b1;                               // [RQ2]
                            next_icr_set[ENABLE_BIT] = 1'b1;                  // [RQ2]
                        end
                        if (dec_retlit) begin
                            next_accumulator = instr[LIT_HI:LIT_LO];          // [RQ4]
                        end
                    end else begin
                        next_pc = pc + PC_W'(1);
                        if (dec_rot) begin
                            next_carry = file_rdata[MSB_BIT];                 // [RQ10]
                            if (instr[DEST_BIT] == DEST_ACCUM) begin
                                next_accumulator = rot_result;                // [RQ9]
                            end else begin
                                next_file_we = 1'b1;                          // [RQ9]
                                next_file_addr = instr[FADDR_HI:FADDR_LO];
                                next_file_wdata = rot_result;
                            end
                        end
                    end
                end
            end
            ST_FLUSH: begin
                // Prefetched word is discarded; new fetch from the loaded PC
                next_state = ST_EXEC;                                         // [RQ11]
            end
            default: begin
                next_state = ST_EXEC;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= ST_EXEC;
            pc <= '0;
            accumulator <= ACCUM_RESET;
            carry <= CARRY_RESET;
            global_interrupt_enable <= ENABLE_RESET;
            interrupt_control_set <= BYTE_ZERO;
            stack_pop <= 1'b0;
            flush <= 1'b0;
            file_we <= 1'b0;
            file_addr <= FADDR_ZERO;
            file_wdata <= BYTE_ZERO;
        end else begin
            state <= next_state;
            pc <= next_pc;
            accumulator <= next_accumulator;
            carry <= next_carry;
            global_interrupt_enable <= next_enable;
            interrupt_control_set <= next_icr_set;
            stack_pop <= next_stack_pop;
            flush <= next_flush;
            file_we <= next_file_we;
            file_addr <= next_file_addr;
            file_wdata <= next_file_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_reti_pop;
        go && dec_reti |=> stack_pop && pc == $past(top_of_stack);
    endproperty
    a_reti_pop: assert property (p_reti_pop) else $error("interrupt return did not pop into pc"); // [RQ1]

    property p_reti_gie;
        go && dec_reti |=> global_interrupt_enable && interrupt_control_set[ENABLE_BIT] && carry == $past(carry);
    endproperty
    a_reti_gie: assert property (p_reti_gie) else $error("interrupt return did not set enable"); // [RQ2]

    property p_reti_two_cycles;
        go && dec_reti |=> state == ST_FLUSH ##1 state == ST_EXEC && !flush;
    endproperty
    a_reti_two_cycles: assert property (p_reti_two_cycles) else $error("interrupt return not two cycles"); // [RQ3]

    property p_retlit_accum;
        go && dec_retlit |=> accumulator == $past(instr[LIT_HI:LIT_LO]);
    endproperty
    a_retlit_accum: assert property (p_retlit_accum) else $error("literal not loaded"); // [RQ4]

    property p_retlit_pop;
        go && dec_retlit |=> stack_pop && pc == $past(top_of_stack) && carry == $past(carry)
            && global_interrupt_enable == $past(global_interrupt_enable);
    endproperty
    a_retlit_pop: assert property (p_retlit_pop) else $error("literal return did not pop"); // [RQ5]

    property p_retlit_cycles;
        go && dec_retlit |=> flush ##1 (state == ST_EXEC && $stable(pc));
    endproperty
    a_retlit_cycles: assert property (p_retlit_cycles) else $error("literal return not two cycles"); // [RQ6]

    property p_ret_pop;
        go && instr == RETURN_CODE |=> stack_pop && pc == $past(top_of_stack) && carry == $past(carry)
            && global_interrupt_enable == $past(global_interrupt_enable);
    endproperty
    a_ret_pop: assert property (p_ret_pop) else $error("return did not pop"); // [RQ7]

    property p_ret_cycles;
        go && instr == RETURN_CODE |=> flush ##1 !flush && state == ST_EXEC;
    endproperty
    a_ret_cycles: assert property (p_ret_cycles) else $error("return not two cycles"); // [RQ8]

    property p_dest_select;
        go && dec_rot |=> file_we == $past(instr[DEST_BIT])
            && (file_we || accumulator == {$past(file_rdata[MSB_BIT-1:0]), $past(carry)});
    endproperty
    a_dest_select: assert property (p_dest_select) else $error("wrong destination"); // [RQ9]

    property p_rotate;
        go && dec_rot |=> carry == $past(file_rdata[MSB_BIT]) && !flush
            && pc == $past(pc) + PC_W'(1);
    endproperty
    a_rotate: assert property (p_rotate) else $error("rotate result wrong"); // [RQ10]

    property p_flush_nop;
        flush |-> state == ST_FLUSH ##1 $stable(pc) && !stack_pop && !file_we;
    endproperty
    a_flush_nop: assert property (p_flush_nop) else $error("flush cycle not a no-operation"); // [RQ11]

    c_reti: cover property (go && dec_reti ##2 go);
    c_retlit: cover property (go && dec_retlit);
    c_rot_file: cover property (go && dec_rot && instr[DEST_BIT]);
    c_rot_accum: cover property (go && dec_rot && !instr[DEST_BIT]);

endmodule : return_and_rotate_exec

`default_nettype wire

// file: return_and_rotate_pkg.sv
/*
 * Constants for the return and rotate execution block: encodings, field
 * positions, bit positions and reset values.
 * Assumes 14-bit instruction words and an 8-bit data path.
 */
package return_and_rotate_pkg;
    localparam int INSTR_W = 14;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;
    localparam int DEF_PC_W = 13;

    // Fixed encodings
    localparam logic [13:0] RETURN_FROM_INTERRUPT_CODE = 14'h0009;

    // Return with literal: top four bits fixed, bits 9:8 ignored
    localparam int RETLIT_OP_HI = 13;
    localparam int RETLIT_OP_LO = 10;
    localparam logic [3:0] RETLIT_OP = 4'hd;
    localparam int LIT_HI = 7;
    localparam int LIT_LO = 0;

    // Rotate left through carry: 00 1101 dfff ffff
    localparam int ROT_OP_HI = 13;
    localparam int ROT_OP_LO = 8;
    localparam logic [5:0] ROT_OP = 6'h0d;
    localparam int DEST_BIT = 7;
    localparam int FADDR_HI = 6;
    localparam int FADDR_LO = 0;
    localparam logic DEST_ACCUM = 1'h0;

    // Global interrupt enable position in the interrupt control register
    localparam int ENABLE_BIT = 7;
    localparam int MSB_BIT = 7;

    // Reset values
    localparam logic [7:0] ACCUM_RESET = 8'h00;
    localparam logic CARRY_RESET = 1'h0;
    localparam logic ENABLE_RESET = 1'h0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [6:0] FADDR_ZERO = 7'h00;

    typedef enum logic {ST_EXEC, ST_FLUSH} exec_state_t;
endpackage : return_and_rotate_pkg

// file: return_and_rotate_exec_tb.sv
/*
 * Self-checking bench for the return and rotate execution block.
 * Assumes the package and the block are compiled first; the bench plays
 * fetch unit, return stack and file register file.
 */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e, m) begin checks_done++; if ((a) !== (e)) begin fails++; $display("FAIL %0t %s", $time, m); end end
module return_and_rotate_exec_tb_top;
    import return_and_rotate_pkg::*;
    localparam int TB_PC_W = DEF_PC_W;
    localparam logic [13:0] RET_CODE = 14'h0008;
    typedef struct packed {
        logic [TB_PC_W-1:0] pc;
        logic [7:0] acc;
        logic c;
        logic ie;
        logic [7:0] icset;
        logic pop;
        logic we;
        logic [6:0] addr;
        logic [7:0] wdata;
    } note_t;
    logic clk = 1'b0;
    logic rst_b, instr_valid, carry, global_interrupt_enable, stack_pop, flush, file_we;
    logic [13:0] instr;
    logic [TB_PC_W-1:0] top_of_stack, pc;
    logic [7:0] file_rdata, accumulator, interrupt_control_set, file_wdata;
    logic [6:0] file_addr;
    int fails = 0;
    int checks_done = 0;
    int seed;
    note_t m, n;
    note_t notes[$];

    return_and_rotate_exec #(.PC_W(TB_PC_W), .RETURN_CODE(RET_CODE)) u_dut (
        .clk(clk), .rst_b(rst_b), .instr_valid(instr_valid), .instr(instr),
        .top_of_stack(top_of_stack), .file_rdata(file_rdata), .pc(pc), .accumulator(accumulator),
        .carry(carry), .global_interrupt_enable(global_interrupt_enable),
        .interrupt_control_set(interrupt_control_set), .stack_pop(stack_pop), .flush(flush),
        .file_we(file_we), .file_addr(file_addr), .file_wdata(file_wdata));

    initial begin
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        if (fails == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test

    // One instruction; a pop is followed by a cycle whose word must be ignored
    task automatic exec_one(input logic v, input logic [13:0] ins);
        logic popi;
        @(negedge clk);
        instr_valid = v;
        instr = ins;
        top_of_stack = TB_PC_W'($urandom);
        file_rdata = 8'($urandom);
        m.icset = BYTE_ZERO;
        m.pop = 1'b0;
        m.we = 1'b0;
        popi = v && (ins == RETURN_FROM_INTERRUPT_CODE || ins[RETLIT_OP_HI:RETLIT_OP_LO] == RETLIT_OP
            || ins == RET_CODE);
        if (popi) begin
            m.pc = top_of_stack;
            m.pop = 1'b1;
        end else if (v) m.pc = m.pc + 1'b1;
        if (v && ins == RETURN_FROM_INTERRUPT_CODE) begin
            m.ie = 1'b1;
            m.icset = 8'h80;
        end
        if (v && ins[RETLIT_OP_HI:RETLIT_OP_LO] == RETLIT_OP) m.acc = ins[LIT_HI:LIT_LO];
        if (v && ins[ROT_OP_HI:ROT_OP_LO] == ROT_OP) begin
            if (ins[DEST_BIT] == DEST_ACCUM) m.acc = {file_rdata[6:0], m.c};
            else begin
                m.we = 1'b1;
                m.addr = ins[FADDR_HI:FADDR_LO];
                m.wdata = {file_rdata[6:0], m.c};
            end
            m.c = file_rdata[MSB_BIT];
        end
        notes.push_back(m);
        if (popi) begin
            @(negedge clk);
            instr = {ROT_OP, 1'b1, 7'($urandom)};
            file_rdata = 8'($urandom);
            m.icset = BYTE_ZERO;
            m.pop = 1'b0;
            notes.push_back(m);
        end
    endtask : exec_one

    // Drops valid so a leftover word is not taken after the last note
    task automatic drain();
        int k;
        k = 0;
        @(negedge clk);
        instr_valid = 1'b0;
        while (notes.size() > 0 && k < 10) begin
            @(negedge clk);
            k++;
        end
        if (notes.size() > 0) fails++;
    endtask : drain

    task automatic check_reset();
        `CHK({pc, accumulator, carry, global_interrupt_enable}, '0, "reset state")
        `CHK({stack_pop, flush, file_we, interrupt_control_set}, '0, "reset pulses")
    endtask : check_reset

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        #1;
        if (notes.size() > 0) begin
            n = notes.pop_front();
            `CHK(pc, n.pc, "pc")
            `CHK(accumulator, n.acc, "accumulator")
            `CHK(carry, n.c, "carry")
            `CHK({global_interrupt_enable, interrupt_control_set}, {n.ie, n.icset}, "interrupt enable")
            `CHK({stack_pop, flush}, {n.pop, n.pop}, "pop or flush")
            `CHK({file_we, file_addr, file_wdata}, {n.we, n.addr, n.wdata}, "file write")
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        finish_test();
    end

    initial begin
        rst_b = 1'b0;
        instr_valid = 1'b0;
        instr = 14'h0000;
        top_of_stack = '0;
        file_rdata = 8'h00;
        m = '0;
        seed = $urandom(36084);
        repeat (6) @(posedge clk);
        check_reset();
        @(negedge clk);
        rst_b = 1'b1;
        exec_one(1'b1, RETURN_FROM_INTERRUPT_CODE);
        for (int i = 0; i < 4; i++) exec_one(1'b1, {RETLIT_OP, 2'(i), 8'($urandom)});
        exec_one(1'b1, RET_CODE);
        for (int i = 0; i < 12; i++) exec_one(1'b1, {ROT_OP, 8'($urandom)});
        // Near misses of the fixed codes only advance the counter
        exec_one(1'b1, 14'h0019);
        exec_one(1'b1, 14'h2009);
        exec_one(1'b1, {6'h30, 8'($urandom)});
        exec_one(1'b0, RETURN_FROM_INTERRUPT_CODE);
        exec_one(1'b1, RET_CODE);
        drain();
        rst_b = 1'b0;
        #1;
        check_reset();
        m = '0;
        @(negedge clk);
        rst_b = 1'b1;
        exec_one(1'b1, {ROT_OP, 1'b0, 7'($urandom)});
        exec_one(1'b1, {RETLIT_OP, 2'h3, 8'($urandom)});
        drain();
        finish_test();
    end
endmodule : return_and_rotate_exec_tb_top
`undef CHK
`default_nettype wire
